// [core/csr_map.vh]
`ifndef CSR_MAP_VH
`define CSR_MAP_VH

// Register indexes; the byte address is four times the index.
`define CSR_IDX_SETUP0 8'h3A
`define CSR_IDX_CMD0 8'h3B
`define CSR_IDX_REC0 8'h3C
`define CSR_IDX_SETUP1 8'h3D
`define CSR_IDX_CMD1 8'h3E
`define CSR_IDX_REC1 8'h3F
`define CSR_IDX_IOWIN 8'h50
`define CSR_IDX_CTRL 8'h51
`define CSR_IDX_STAT 8'h52

// Reset values.
`define CSR_RST_SETUP 8'h01
`define CSR_RST_CMD0 8'h05
`define CSR_RST_CMD1 8'h14
`define CSR_RST_REC 8'h00

// Timing register fields.
`define CSR_F_PRE_HI 7
`define CSR_F_PRE_LO 6
`define CSR_F_VAL_HI 5
`define CSR_F_VAL_LO 0

// Window control: timer set select for I/O window 0 and 1.
`define CSR_F_WIN0_SET 3
`define CSR_F_WIN1_SET 7

// Control fields.
`define CSR_F_ATA 0
`define CSR_F_RESET 1
`define CSR_F_LED 2
`define CSR_F_VU 3
`define CSR_F_MS 4
`define CSR_F_CSEL 5

// Socket clock divider and the resulting period.
`define CSR_CLK_NS 20
`define CSR_SOCK_DIV 2
`define CSR_TCP_NS (`CSR_SOCK_DIV * `CSR_CLK_NS)

`endif

// [core/csr_socket.v]
`timescale 1ns/1ps
`include "csr_map.vh"

module csr_socket #(
  parameter AW = 8,
  parameter CAW = 26,
  parameter DW = 16
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire [AW-1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_cyc_req,
  input wire i_cyc_write,
  input wire i_cyc_io,
  input wire i_cyc_win,
  input wire [CAW-1:0] i_cyc_addr,
  input wire [DW-1:0] i_cyc_wdata,
  output wire o_cyc_ready,
  output reg o_cyc_done,
  output reg o_cyc_err,
  output reg [DW-1:0] o_cyc_rdata,
  output reg o_card_ce1_n,
  output reg o_card_ce2_n,
  output reg o_card_oe_n,
  output reg o_card_we_n,
  output reg o_card_iord_n,
  output reg o_card_iowr_n,
  output reg [CAW-1:0] o_card_addr,
  output reg [DW-1:0] o_card_d,
  output reg o_card_d_oe,
  input wire [DW-1:0] i_card_d,
  input wire i_card_wait_n,
  output reg o_card_reset,
  output reg o_card_spkr_n,
  output wire o_card_reg_n
);

  localparam ST_IDLE = 2'b00;
  localparam ST_SETUP = 2'b01;
  localparam ST_CMD = 2'b10;
  localparam ST_REC = 2'b11;

  // Turns a timing register into a length in socket clocks.
  // The widest setting, 63 weighted by 4096 plus one, still fits the 18-bit count.
  function [17:0] csr_len;
    input [7:0] r;
    reg [17:0] base;
    begin
      base = {12'h000, r[`CSR_F_VAL_HI:`CSR_F_VAL_LO]};
      case (r[`CSR_F_PRE_HI:`CSR_F_PRE_LO])
        2'b00: csr_len = base + 18'h00001;
        2'b01: csr_len = (base << 4) + 18'h00001;
        2'b10: csr_len = (base << 8) + 18'h00001;
        default: csr_len = (base << 12) + 18'h00001;
      endcase
    end
  endfunction

  // True on the last socket clock of a phase; shared by all three phases.
  function csr_last;
    input [17:0] c;
    begin
      csr_last = (c == 18'h00001);
    end
  endfunction

  reg [7:0] setup0_r;
  reg [7:0] setup1_r;
  reg [7:0] cmd0_r;
  reg [7:0] cmd1_r;
  reg [7:0] recovery_time_set0_r;
  reg [7:0] recovery_time_set1_r;
  reg [7:0] iowin_r;
  reg [5:0] ctrl_r;
  reg rd_ack_r;
  reg tick_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [17:0] cnt_r;
  reg [17:0] cnt_nxt;
  reg set_r;
  reg wr_r;
  reg io_r;
  reg [CAW-1:0] addr_r;
  reg [DW-1:0] wdata_r;
  reg wait_meta_r;
  reg wait_n_r;
  reg [DW-1:0] d_meta_r;
  reg [DW-1:0] d_r;
  reg [7:0] setup_sel;
  reg [7:0] cmd_sel;
  reg [7:0] rec_sel;
  reg [31:0] rdata_nxt;
  wire ata;
  wire take;
  wire req_set;
  wire bus_rd;
  wire bus_wr;
  wire launch;
  wire pin_wr;
  wire [CAW-1:0] pin_addr;
  wire [DW-1:0] pin_wdata;

  assign ata = ctrl_r[`CSR_F_ATA];
  assign bus_rd = i_avs_read & ~i_avs_write;
  assign bus_wr = i_avs_write & ~i_avs_read;

  // Reads wait one cycle so read data come from a flip-flop; writes never wait.
  assign o_avs_waitrequest = bus_rd & ~rd_ack_r;

  // The DMA acknowledge role of this pin is not supported, so it stays idle.
  assign o_card_reg_n = 1'b1;

  // Register writes; timing changes reach the next phase load at once.
  // A rewrite while a cycle runs applies at the next phase load, so software should wait for idle.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      setup0_r <= `CSR_RST_SETUP;
      setup1_r <= `CSR_RST_SETUP;
      cmd0_r <= `CSR_RST_CMD0;
      cmd1_r <= `CSR_RST_CMD1;
      recovery_time_set0_r <= `CSR_RST_REC;
      recovery_time_set1_r <= `CSR_RST_REC;
      iowin_r <= 8'h00;
      ctrl_r <= 6'h00;
    end else if (bus_wr) begin
      case (i_avs_address)
        `CSR_IDX_SETUP0: setup0_r <= i_avs_writedata[7:0];
        `CSR_IDX_CMD0: cmd0_r <= i_avs_writedata[7:0];
        `CSR_IDX_REC0: recovery_time_set0_r <= i_avs_writedata[7:0];
        `CSR_IDX_SETUP1: setup1_r <= i_avs_writedata[7:0];
        `CSR_IDX_CMD1: cmd1_r <= i_avs_writedata[7:0];
        `CSR_IDX_REC1: recovery_time_set1_r <= i_avs_writedata[7:0];
        `CSR_IDX_IOWIN: iowin_r <= i_avs_writedata[7:0];
        `CSR_IDX_CTRL: ctrl_r <= i_avs_writedata[5:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Read mux; unmapped indexes read as zero.
  always @* begin
    rdata_nxt = 32'h00000000;
    case (i_avs_address)
      `CSR_IDX_SETUP0: rdata_nxt[7:0] = setup0_r;
      `CSR_IDX_CMD0: rdata_nxt[7:0] = cmd0_r;
      `CSR_IDX_REC0: rdata_nxt[7:0] = recovery_time_set0_r;
      `CSR_IDX_SETUP1: rdata_nxt[7:0] = setup1_r;
      `CSR_IDX_CMD1: rdata_nxt[7:0] = cmd1_r;
      `CSR_IDX_REC1: rdata_nxt[7:0] = recovery_time_set1_r;
      `CSR_IDX_IOWIN: rdata_nxt[7:0] = iowin_r;
      `CSR_IDX_CTRL: rdata_nxt[5:0] = ctrl_r;
      `CSR_IDX_STAT: rdata_nxt[4:0] = {wait_n_r, ata, state_r, state_r != ST_IDLE};
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  // Read data register and the one-cycle acknowledge.
  // A read dropped before its answer leaves the acknowledge high for one cycle; a read starting then gets that stale data at once.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_ack_r <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end else begin
      rd_ack_r <= bus_rd & ~rd_ack_r;
      if (bus_rd & ~rd_ack_r) begin
        o_avs_readdata <= rdata_nxt;
      end
    end
  end

  // Socket clock enable: one pulse every two bus clocks.
  // Running from reset puts the first ready at the first clock edge.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= ~tick_r;
    end
  end

  // Wait and card data come from the socket, so they are synchronised first.
  // The data bus is only latched on the last tick of the command strobe, which can be its first tick at the shortest command setting.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_meta_r <= 1'b1;
      wait_n_r <= 1'b1;
      d_meta_r <= {DW{1'b0}};
      d_r <= {DW{1'b0}};
    end else begin
      wait_meta_r <= i_card_wait_n;
      wait_n_r <= wait_meta_r;
      d_meta_r <= i_card_d;
      d_r <= d_meta_r;
    end
  end

  // A new cycle is taken only on a socket clock edge while idle.
  assign o_cyc_ready = (state_r == ST_IDLE) & tick_r;
  assign take = i_cyc_req & o_cyc_ready;
  assign req_set = i_cyc_win ? iowin_r[`CSR_F_WIN1_SET] : iowin_r[`CSR_F_WIN0_SET];

  // A memory request in ATA mode is refused outright, so it never loads the cycle registers.
  assign launch = take & ~(ata & ~i_cyc_io);

  // At the launch edge the captured copies still hold the previous cycle, so the
  // pins take the request itself; otherwise a stale chip select would flash for a clock.
  assign pin_wr = launch ? i_cyc_write : wr_r;
  assign pin_addr = launch ? i_cyc_addr : addr_r;
  assign pin_wdata = launch ? i_cyc_wdata : wdata_r;

  // Live timing registers of the selected set, read at every phase load.
  always @* begin
    setup_sel = (take ? req_set : set_r) ? setup1_r : setup0_r;
    cmd_sel = set_r ? cmd1_r : cmd0_r;
    rec_sel = set_r ? recovery_time_set1_r : recovery_time_set0_r;
  end

  // Cycle sequencer: setup, command, then recovery after the strobe.
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (launch) begin
          state_nxt = ST_SETUP;
          cnt_nxt = csr_len(setup_sel);
        end
      end
      ST_SETUP: begin
        if (tick_r) begin
          if (csr_last(cnt_r)) begin
            state_nxt = ST_CMD;
            cnt_nxt = csr_len(cmd_sel);
          end else begin
            cnt_nxt = cnt_r - 18'h00001;
          end
        end
      end
      ST_CMD: begin
        // A low wait (IOCHRDY in ATA mode) freezes the command count.
        if (tick_r && wait_n_r) begin
          if (csr_last(cnt_r)) begin
            state_nxt = ST_REC;
            cnt_nxt = csr_len(rec_sel);
          end else begin
            cnt_nxt = cnt_r - 18'h00001;
          end
        end
      end
      ST_REC: begin
        if (tick_r) begin
          if (csr_last(cnt_r)) begin
            state_nxt = ST_IDLE;
          end else begin
            cnt_nxt = cnt_r - 18'h00001;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers, request capture and completion pulses.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 18'h00000;
      set_r <= 1'b0;
      wr_r <= 1'b0;
      io_r <= 1'b0;
      addr_r <= {CAW{1'b0}};
      wdata_r <= {DW{1'b0}};
      o_cyc_done <= 1'b0;
      o_cyc_err <= 1'b0;
      o_cyc_rdata <= {DW{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      // Memory cycles are refused in ATA mode and never touch the socket.
      o_cyc_err <= take & ata & ~i_cyc_io;
      o_cyc_done <= (state_r == ST_REC) & (state_nxt == ST_IDLE);
      // Only a launched cycle is captured, so a refused one leaves the pins alone.
      if (launch) begin
        set_r <= req_set;
        wr_r <= i_cyc_write;
        io_r <= i_cyc_io;
        addr_r <= i_cyc_addr;
        wdata_r <= i_cyc_wdata;
      end
      if (state_r == ST_CMD && state_nxt == ST_REC && !wr_r) begin
        o_cyc_rdata <= d_r;
      end
    end
  end

  // Socket pins are registered from the next state so strobes never glitch.
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_card_ce1_n <= 1'b1;
      o_card_ce2_n <= 1'b1;
      o_card_oe_n <= 1'b1;
      o_card_we_n <= 1'b1;
      o_card_iord_n <= 1'b1;
      o_card_iowr_n <= 1'b1;
      o_card_addr <= {CAW{1'b0}};
      o_card_d <= {DW{1'b0}};
      o_card_d_oe <= 1'b0;
      o_card_reset <= 1'b0;
      o_card_spkr_n <= 1'b1;
    end else begin
      o_card_iord_n <= ~(state_nxt == ST_CMD & io_r & ~wr_r);
      o_card_iowr_n <= ~(state_nxt == ST_CMD & io_r & wr_r);
      o_card_d <= pin_wdata;
      o_card_d_oe <= (state_nxt != ST_IDLE) & pin_wr;
      if (ata) begin
        o_card_oe_n <= 1'b0;
        o_card_we_n <= 1'b1;
        o_card_ce1_n <= ~(state_nxt != ST_IDLE & ~pin_addr[9]);
        o_card_ce2_n <= ~(state_nxt != ST_IDLE & pin_addr[9]);
        // Unused address lines sit at zero so they do not toggle under the disk.
        o_card_addr <= {CAW{1'b0}};
        o_card_addr[9] <= ~(state_nxt != ST_IDLE & pin_addr[9]);
        o_card_addr[2:0] <= pin_addr[2:0];
        o_card_addr[23] <= ctrl_r[`CSR_F_VU];
        o_card_addr[24] <= ctrl_r[`CSR_F_MS];
        o_card_addr[25] <= ctrl_r[`CSR_F_CSEL];
        o_card_reset <= ~ctrl_r[`CSR_F_RESET];
        o_card_spkr_n <= ~ctrl_r[`CSR_F_LED];
      end else begin
        o_card_oe_n <= ~(state_nxt == ST_CMD & ~io_r & ~wr_r);
        o_card_we_n <= ~(state_nxt == ST_CMD & ~io_r & wr_r);
        o_card_ce1_n <= ~(state_nxt != ST_IDLE);
        o_card_ce2_n <= ~(state_nxt != ST_IDLE);
        o_card_addr <= pin_addr;
        o_card_reset <= ctrl_r[`CSR_F_RESET];
        o_card_spkr_n <= 1'b1;
      end
    end
  end

endmodule // csr_socket

// [verif/csr_socket_sva.sv]
`timescale 1ns/1ps
// Watches the bus handshake and the socket strobes of the block.
module csr_socket_sva (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire i_cyc_req,
  input wire i_cyc_io,
  input wire o_cyc_ready,
  input wire o_cyc_done,
  input wire o_cyc_err,
  input wire o_card_we_n,
  input wire o_card_iord_n,
  input wire o_card_iowr_n,
  input wire o_card_ce1_n,
  input wire o_card_reg_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // High while an I/O command strobe is driven.
  wire io_on = !o_card_iord_n || !o_card_iowr_n;

  property p_tick; o_cyc_ready |=> !o_cyc_ready; endproperty
  a_tick: assert property (p_tick) else $error("ready on two clocks in a row");
  property p_busy; io_on |-> !o_cyc_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready during a command");
  property p_done; o_cyc_done |-> !io_on && o_card_we_n ##1 !o_cyc_done; endproperty
  a_done: assert property (p_done) else $error("done with strobe or too long");
  property p_rec; $fell(io_on) |-> !o_cyc_done ##1 !o_cyc_done; endproperty
  a_rec: assert property (p_rec) else $error("recovery shorter than one tick");
  property p_err; o_cyc_err |-> $past(i_cyc_req && o_cyc_ready && !i_cyc_io); endproperty
  a_err: assert property (p_err) else $error("error without memory request");
  property p_quiet; o_cyc_err |-> o_card_we_n && !io_on && o_card_ce1_n ##1 !o_cyc_err; endproperty
  a_quiet: assert property (p_quiet) else $error("pins moved on refused cycle");
  property p_wr; i_avs_write |-> !o_avs_waitrequest; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_rd; i_avs_read && !$past(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest; endproperty
  a_rd: assert property (p_rd) else $error("read answer timing wrong");
  property p_dack; o_card_reg_n; endproperty
  a_dack: assert property (p_dack) else $error("select line moved");
endmodule // csr_socket_sva

bind csr_socket csr_socket_sva csr_socket_sva_i (.*);

// [verif/csr_card_model.sv]
`timescale 1ns/1ps
// An I/O card or disk that answers reads and can stretch a command.
module csr_card_model (
  input wire i_clk,
  input wire i_slow,
  input wire i_iord_n,
  input wire [25:0] i_addr,
  output logic [15:0] o_d = 16'h0000,
  output logic o_wait_n = 1'b1
);
  int cnt = 0;
  // The data bus flips when not read, so stale data can never pass as a read.
  always @(posedge i_clk) begin
    cnt <= i_iord_n ? 0 : cnt + 1;
    o_d <= i_iord_n ? ~o_d : {8'hA5, i_addr[7:0]};
    o_wait_n <= !(i_slow && !i_iord_n && cnt < 3);
  end
endmodule // csr_card_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
  logic i_clk = 0, i_reset_n = 0, i_avs_read = 0, i_avs_write = 0, o_avs_waitrequest;
  logic [7:0] i_avs_address = 8'h00;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
  logic i_cyc_req = 0, i_cyc_write = 0, i_cyc_io = 0, i_cyc_win = 0, o_cyc_ready, o_cyc_done, o_cyc_err;
  logic [25:0] i_cyc_addr = 26'h0, o_card_addr, ad;
  logic [15:0] i_cyc_wdata = 16'h0, o_cyc_rdata, o_card_d, i_card_d, rd, wd;
  logic o_card_ce1_n, o_card_ce2_n, o_card_oe_n, o_card_we_n, o_card_iord_n, o_card_iowr_n, o_card_d_oe;
  logic i_card_wait_n, o_card_reset, o_card_spkr_n, o_card_reg_n, slow = 0, e;
  logic [4:0] pins;
  int errors = 0, compares = 0, cmd, rec, bc, br;

  csr_socket csr_socket_i (.*);
  csr_card_model csr_card_model_i (.i_clk(i_clk), .i_slow(slow), .i_iord_n(o_card_iord_n),
    .i_addr(o_card_addr), .o_d(i_card_d), .o_wait_n(i_card_wait_n));

  // Free-running 50 MHz clock.
  always #10 i_clk = ~i_clk;

  task automatic wrap_up;
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tmo;
    errors++;
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One register access; the request stands until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= {24'h000000, d};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 50) tmo();
  endtask

  // One socket cycle; counts command and recovery clocks and samples the pins mid-command.
  task automatic cyc(input logic io, input logic w, input logic win, input logic [25:0] a);
    int n;
    n = 0;
    cmd = 0;
    rec = 0;
    @(posedge i_clk);
    i_cyc_req <= 1'b1;
    i_cyc_io <= io;
    i_cyc_write <= w;
    i_cyc_win <= win;
    i_cyc_addr <= a;
    i_cyc_wdata <= ~a[15:0];
    do begin
      @(posedge i_clk);
      n++;
    end while (o_cyc_ready !== 1'b1 && n < 20);
    i_cyc_req <= 1'b0;
    if (n >= 20) tmo();
    do begin
      @(posedge i_clk);
      n++;
      if ((o_card_iord_n & o_card_iowr_n) === 1'b0) begin
        cmd++;
        pins = {o_card_ce1_n, o_card_ce2_n, o_card_oe_n, o_card_we_n, o_card_d_oe};
        ad = o_card_addr;
        wd = o_card_d;
      end else if (cmd > 0) rec++;
    end while (o_cyc_done !== 1'b1 && o_cyc_err !== 1'b1 && n < 20000);
    e = o_cyc_err;
    rd = o_cyc_rdata;
    if (n >= 20000) tmo();
  endtask

  task automatic t_regs;
    bus(0, 8'h3C, 8'h00);
    chk(q, 32'h0);
    bus(1, 8'h3F, 8'hC5);
    bus(0, 8'h3F, 8'h00);
    chk(q, 32'hC5);
    bus(0, 8'h20, 8'h00);
    chk(q, 32'h0);
    bus(1, 8'h3F, 8'h00);
  endtask

  // Recovery grows by two clocks per tick of weight times multiplier.
  task automatic t_rec;
    cyc(1, 0, 0, 26'h0000123);
    br = rec;
    bc = cmd;
    chk(rd, 16'hA523);
    for (int k = 0; k < 4; k++) begin
      bus(1, 8'h3C, {k[1:0], 6'h01});
      cyc(1, 0, 0, 26'h40);
      chk(rec - br, 2 << (4 * k));
    end
    bus(1, 8'h3C, 8'h3F);
    cyc(1, 1, 0, 26'h40);
    chk(rec - br, 126);
    chk(wd, 16'hFFBF);
    bus(1, 8'h3C, 8'h00);
    bus(1, 8'h3B, 8'h41);
    cyc(1, 0, 0, 26'h40);
    chk(cmd - bc, 22);
    bus(1, 8'h3B, 8'h05);
  endtask

  // Window control bits pick the timer set per window.
  task automatic t_set;
    bus(1, 8'h3F, 8'h05);
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h50, i[1] ? 8'h80 : 8'h08);
      cyc(1, 0, i[0], 26'h40);
      chk(rec - br, (i[0] == i[1]) ? 10 : 0);
    end
    bus(1, 8'h50, 8'h00);
    bus(1, 8'h3F, 8'h00);
  endtask

  task automatic t_ata;
    bus(1, 8'h51, 8'h3D);
    bus(0, 8'h51, 8'h00);
    chk(q, 32'h3D);
    cyc(0, 0, 0, 26'h40);
    chk({e, 31'(cmd)}, 32'h80000000);
    cyc(1, 1, 0, 26'h205);
    chk(pins, 5'b10011);
    chk({ad[22:0], wd}, {23'h5, 16'hFDFA});
    chk({o_card_reset, o_card_spkr_n}, 2'b10);
    chk(ad[25:23], 3'b111);
    cyc(1, 0, 0, 26'h003);
    chk(pins, 5'b01010);
    slow <= 1'b1;
    cyc(1, 0, 0, 26'h007);
    slow <= 1'b0;
    chk({rd, 1'(cmd > bc)}, {16'hA507, 1'b1});
    bus(1, 8'h3F, 8'h05);
    bus(1, 8'h50, 8'h08);
    cyc(1, 0, 0, 26'h003);
    chk(rec - br, 10);
    bus(1, 8'h50, 8'h00);
    bus(1, 8'h3F, 8'h00);
    bus(1, 8'h51, 8'h00);
    bus(0, 8'h51, 8'h00);
    chk({o_card_reset, o_card_spkr_n}, 2'b01);
  endtask

  // Reset for eight clocks, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_rec();
    t_set();
    t_ata();
    wrap_up();
  end
endmodule // tb
